/* File: logic/pim_monitor.sv */
// polled input monitor top
`timescale 1ns/1ps
`include "pim_map.svh"
module pim_monitor #(parameter int PINS = `PIM_PIN_COUNT)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic boundary,
   input wire logic in_define,
   input wire logic [`PIM_IDX_W-1:0] in_index,
   input wire logic in_level,
   input wire logic out_define,
   input wire logic [`PIM_IDX_W-1:0] out_index,
   input wire logic out_level,
   input wire logic mode_define,
   input wire logic [1:0] mode_value,
   input wire logic run_enable,
   input wire logic wait_enable,
   input wire logic latch_clear,
   input wire logic [PINS-1:0] pin_in,
   output logic [PINS-1:0] pin_out,
   output logic [PINS-1:0] pin_oe,
   output logic poll_hit,
   output logic run_request,
   output logic halt,
   output logic stat_we,
   output logic [7:0] stat_addr,
   output logic [7:0] stat_data
);
   if (PINS != `PIM_PIN_COUNT)
   begin : g_bad_pins
      $error("pim_monitor serves exactly 16 pins");
   end

   pim_sync_if #(.WIDTH(PINS)) sif ();
   assign sif.raw = pin_in;
   pim_sync #(.WIDTH(PINS)) u_sync (.clk(clk), .rst(rst), .sif(sif));

   logic [PINS-1:0] in_mask, in_act, out_mask, out_act, drive, latched;
   logic [PINS-1:0] next_in_mask, next_in_act, next_out_mask, next_out_act;
   logic [PINS-1:0] next_drive, next_latched;
   pim_pkg::pim_mode_t mode, next_mode;
   pim_pkg::pim_state_t state, next_state;
   logic next_hit, next_run, next_halt, next_we;
   logic [7:0] next_addr, next_data;
   logic [PINS-1:0] match;
   logic any_match;

   function automatic logic [PINS-1:0] onehot(input logic [`PIM_IDX_W-1:0] idx);
      onehot = '0;
      onehot[idx] = 1'b1;
   endfunction

   // both banks are one flat vector, so no bank select gates the match
   assign match = in_mask & ~(sif.synced ^ in_act);
   assign any_match = |match;

   always_comb
   begin
      next_in_mask = in_mask;
      next_in_act = in_act;
      next_out_mask = out_mask;
      next_out_act = out_act;
      next_mode = mode;
      next_drive = drive;
      next_latched = latched;
      next_state = state;
      next_hit = 1'b0;
      next_run = 1'b0;
      next_halt = halt;
      next_we = 1'b0;
      next_addr = stat_addr;
      next_data = stat_data;
      if (in_define)
      begin
         next_in_mask = in_mask | onehot(in_index);
         next_in_act[in_index] = in_level;
         next_out_mask = out_mask & ~onehot(in_index);
      end
      if (out_define)
      begin
         next_out_mask = next_out_mask | onehot(out_index);
         next_out_act[out_index] = out_level;
         next_in_mask = next_in_mask & ~onehot(out_index);
         next_drive[out_index] = ~out_level;
      end
      if (mode_define)
      begin
         next_mode = mode_value;
         next_latched = '0;
      end
      if (latch_clear)
         next_latched = '0;
      unique case (state)
         pim_pkg::PIM_IDLE:
         begin
            next_halt = 1'b0;
            if (mode != `PIM_MODE_OFF)
               next_state = pim_pkg::PIM_ARMED;
         end
         pim_pkg::PIM_ARMED, pim_pkg::PIM_HIT:
         begin
            if (mode == `PIM_MODE_OFF)
            begin
               next_state = pim_pkg::PIM_IDLE;
               next_halt = 1'b0;
            end
            else if (boundary)
            begin
               next_we = 1'b1;
               next_addr = `PIM_STAT_BASE;
               next_data = match[`PIM_STAT_W-1:0] | next_latched[`PIM_STAT_W-1:0];
               if (any_match)
               begin
                  next_state = pim_pkg::PIM_HIT;
                  next_hit = 1'b1;
                  next_drive = next_out_act;
                  // a clear in the same cycle drops old bits, the new match still wins
                  next_latched = next_latched | match;
                  next_data = next_latched[`PIM_STAT_W-1:0];
                  next_run = run_enable;
                  next_halt = 1'b0;
               end
               else
               begin
                  next_state = pim_pkg::PIM_ARMED;
                  if (mode == `PIM_MODE_CONT)
                     next_drive = ~next_out_act;
                  next_halt = wait_enable;
               end
            end
         end
         default:
            next_state = pim_pkg::PIM_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         in_mask <= '0;
         in_act <= '0;
         out_mask <= '0;
         out_act <= '0;
         drive <= '0;
         latched <= '0;
         mode <= `PIM_MODE_OFF;
         state <= pim_pkg::PIM_IDLE;
         poll_hit <= 1'b0;
         run_request <= 1'b0;
         halt <= 1'b0;
         stat_we <= 1'b0;
         stat_addr <= `PIM_STAT_BASE;
         stat_data <= 8'h00;
      end
      else
      begin
         in_mask <= next_in_mask;
         in_act <= next_in_act;
         out_mask <= next_out_mask;
         out_act <= next_out_act;
         drive <= next_drive;
         latched <= next_latched;
         mode <= next_mode;
         state <= next_state;
         poll_hit <= next_hit;
         run_request <= next_run;
         halt <= next_halt;
         stat_we <= next_we;
         stat_addr <= next_addr;
         stat_data <= next_data;
      end
   end

   assign pin_oe = out_mask;
   assign pin_out = drive & out_mask;

   sequence s_strobe_hit;
      boundary && state != pim_pkg::PIM_IDLE && mode != `PIM_MODE_OFF && any_match && !mode_define;
   endsequence

   sequence s_strobe_miss;
      boundary && state != pim_pkg::PIM_IDLE && mode != `PIM_MODE_OFF && !any_match && !mode_define;
   endsequence

   a_hit_drives_outputs: assert property (@(posedge clk) disable iff (rst)
      s_strobe_hit |=> poll_hit && (pin_out == (out_act & out_mask))) else $error("hit did not drive outputs");
   a_no_poll_off: assert property (@(posedge clk) disable iff (rst)
      (mode == `PIM_MODE_OFF) |=> !poll_hit) else $error("poll hit while mode off");
   a_hit_needs_strobe: assert property (@(posedge clk) disable iff (rst)
      poll_hit |-> $past(boundary)) else $error("hit without boundary");
   a_cont_release: assert property (@(posedge clk) disable iff (rst)
      boundary && state != pim_pkg::PIM_IDLE && mode == `PIM_MODE_CONT && !any_match && !out_define && !mode_define
      |=> pin_out == ($past(~out_act) & out_mask)) else $error("outputs not released");
   a_latched_hold: assert property (@(posedge clk) disable iff (rst)
      s_strobe_miss ##0 (mode != `PIM_MODE_CONT && !out_define && !in_define)
      |=> pin_out == $past(pin_out)) else $error("latched outputs released");
   a_run_on_hit: assert property (@(posedge clk) disable iff (rst)
      run_request |-> poll_hit) else $error("run without hit");
   a_halt_on_miss: assert property (@(posedge clk) disable iff (rst)
      s_strobe_miss ##0 wait_enable |=> halt) else $error("no halt on missed poll");
   a_status_addr: assert property (@(posedge clk) disable iff (rst)
      stat_we |-> stat_addr >= `PIM_STAT_BASE && stat_addr <= `PIM_STAT_LAST) else $error("status address out");
   a_hit_writes_status: assert property (@(posedge clk) disable iff (rst)
      poll_hit |-> stat_we && stat_addr == `PIM_STAT_BASE) else $error("hit without status write");
   a_clear_record: assert property (@(posedge clk) disable iff (rst)
      latch_clear && !boundary |=> latched == '0) else $error("status record not cleared");
   a_in_is_input: assert property (@(posedge clk) disable iff (rst)
      in_define && !out_define |=> !pin_oe[$past(in_index)]) else $error("defined input still driven");
   a_or_condition: assert property (@(posedge clk) disable iff (rst)
      poll_hit |-> $past(|match)) else $error("hit without any match");
endmodule

/* File: logic/pim_map.svh */
// constants for the polled input monitor
`ifndef PIM_MAP_SVH
`define PIM_MAP_SVH
`define PIM_PIN_COUNT 16
`define PIM_IDX_W 4
`define PIM_STAT_BASE 8'h80
`define PIM_STAT_LAST 8'h87
`define PIM_STAT_WORDS 8
`define PIM_STAT_W 8
`define PIM_MODE_OFF 2'h0
`define PIM_MODE_CONT 2'h1
`define PIM_MODE_LATCH 2'h2
`endif

/* File: logic/pim_pkg.sv */
// types for the polled input monitor
package pim_pkg;
   typedef enum logic [1:0]
   {
      PIM_IDLE = 2'h0,
      PIM_ARMED = 2'h1,
      PIM_HIT = 2'h3
   } pim_state_t;
   typedef logic [1:0] pim_mode_t;
endpackage

/* File: logic/pim_sync_if.sv */
// carrier between top and pin synchroniser
`timescale 1ns/1ps
interface pim_sync_if #(parameter int WIDTH = 16);
   logic [WIDTH-1:0] raw;
   logic [WIDTH-1:0] synced;
   modport src (output raw, input synced);
   modport dst (input raw, output synced);
endinterface

/* File: logic/pim_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pim_sync #(parameter int WIDTH = 16)
(
   input wire logic clk,
   input wire logic rst,
   pim_sync_if.dst sif
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] stage;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_stage;
   always_comb
   begin
      next_meta = sif.raw;
      next_stage = meta;
   end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta <= '0;
         stage <= '0;
      end
      else
      begin
         meta <= next_meta;
         stage <= next_stage;
      end
   end
   assign sif.synced = stage;
endmodule

/* File: tb/pim_pins.sv */
// external pin model: undriven pins follow the bench, driven pins loop back
`timescale 1ns/1ps
module pim_pins
(
   input wire logic [15:0] level,
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe,
   output logic [15:0] pin_in
);
   // a pin the monitor drives reads back its own drive
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & level);
endmodule

/* File: tb/test_polled_input_monitor.sv */
// scenario bench for the polled input monitor
`timescale 1ns/1ps
module test_polled_input_monitor;
   logic clk = 0, rst = 1, boundary = 0, in_define = 0, in_level = 0, out_define = 0, out_level = 0;
   logic mode_define = 0, run_enable = 0, wait_enable = 0, latch_clear = 0, poll_hit, run_request, halt;
   logic stat_we;
   logic [3:0] in_index = 4'h0, out_index = 4'h0;
   logic [1:0] mode_value = 2'h0;
   logic [15:0] level = 16'hFFFF, pin_in, pin_out, pin_oe;
   logic [7:0] stat_addr, stat_data;
   int n_errors = 0, n_checks = 0, cyc = 0;
   pim_monitor dut_u (.clk(clk), .rst(rst), .boundary(boundary), .in_define(in_define), .in_index(in_index),
      .in_level(in_level), .out_define(out_define), .out_index(out_index), .out_level(out_level),
      .mode_define(mode_define), .mode_value(mode_value), .run_enable(run_enable), .wait_enable(wait_enable),
      .latch_clear(latch_clear), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .poll_hit(poll_hit),
      .run_request(run_request), .halt(halt), .stat_we(stat_we), .stat_addr(stat_addr), .stat_data(stat_data));
   pim_pins pins_u (.level(level), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
   initial
   begin
      forever #2 clk = ~clk;
   end
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic settle();
      repeat (3) @(negedge clk);
   endtask
   task automatic def_pin(input logic is_out, input logic [3:0] idx, input logic lvl);
      @(negedge clk);
      {in_index, in_level, in_define} = {idx, lvl, ~is_out};
      {out_index, out_level, out_define} = {idx, lvl, is_out};
      @(negedge clk);
      {in_define, out_define} = 2'h0;
   endtask
   task automatic set_mode(input logic [1:0] m);
      @(negedge clk);
      {mode_value, mode_define} = {m, 1'b1};
      @(negedge clk);
      mode_define = 0;
      repeat (2) @(negedge clk);
   endtask
   // one boundary strobe; answer is read in the cycle after it is taken
   task automatic poll(input logic hit, input logic [15:0] out, input logic we);
      @(negedge clk);
      boundary = 1;
      @(negedge clk);
      boundary = 0;
      chk(poll_hit, hit);
      chk(pin_out, out);
      chk(stat_we, we);
      chk(stat_addr, 16'h0080);
      chk(run_request, hit & run_enable);
      chk(halt, wait_enable & we & ~hit);
      if (hit && !level[0])
         chk(stat_data[0], 1'b1);
   endtask
   task automatic t_off();
      def_pin(0, 4'h0, 0);
      def_pin(1, 4'h1, 1);
      chk(pin_oe, 16'h0002);
      level[0] = 0;
      settle();
      poll(0, 16'h0000, 0);
   endtask
   task automatic t_cont();
      set_mode(2'h1);
      poll(1, 16'h0002, 1);
      poll(1, 16'h0002, 1);
      level[0] = 1;
      settle();
      poll(0, 16'h0000, 1);
   endtask
   task automatic t_or();
      def_pin(0, 4'hF, 1);
      level[15] = 1;
      settle();
      poll(1, 16'h0002, 1);
      level[15] = 0;
      settle();
      poll(0, 16'h0000, 1);
   endtask
   task automatic t_actions();
      run_enable = 1;
      level[0] = 0;
      settle();
      poll(1, 16'h0002, 1);
      {run_enable, wait_enable, level[0]} = 3'h3;
      settle();
      poll(0, 16'h0000, 1);
      level[0] = 0;
      settle();
      poll(1, 16'h0002, 1);
      wait_enable = 0;
   endtask
   task automatic t_latch();
      level[0] = 1;
      set_mode(2'h2);
      level[0] = 0;
      settle();
      poll(1, 16'h0002, 1);
      level[0] = 1;
      settle();
      poll(0, 16'h0002, 1);
      chk(stat_data, 16'h0001);
   endtask
   // clear the record, then mode 3 holds like latched, then mode off drops halt and ignores strobes
   task automatic t_clear();
      @(negedge clk);
      latch_clear = 1;
      @(negedge clk);
      latch_clear = 0;
      poll(0, 16'h0002, 1);
      chk(stat_data, 16'h0000);
      set_mode(2'h3);
      level[0] = 0;
      settle();
      poll(1, 16'h0002, 1);
      {wait_enable, level[0]} = 2'h3;
      settle();
      poll(0, 16'h0002, 1);
      set_mode(2'h0);
      chk(halt, 1'b0);
      level[0] = 0;
      settle();
      poll(0, 16'h0002, 0);
      wait_enable = 0;
   endtask
   // reset in mid-run forgets all definitions and the mode
   task automatic t_reset();
      @(negedge clk);
      rst = 1;
      repeat (3) @(negedge clk);
      rst = 0;
      chk(pin_oe | pin_out, 16'h0000);
      chk(stat_we | poll_hit | halt, 1'b0);
      poll(0, 16'h0000, 0);
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_errors++;
         conclude();
      end
   end
   initial
   begin
      repeat (8) @(negedge clk);
      rst = 0;
      chk(pin_oe | pin_out, 16'h0000);
      t_off();
      t_cont();
      t_or();
      t_actions();
      t_latch();
      t_clear();
      t_reset();
      conclude();
   end
endmodule
